// >>> dv/isb_host_model.sv
// host side register access model
`timescale 1ns/1ps
`default_nettype none
module isb_host_model (
    input wire logic SYS_CLK,
    output logic REG_WR, REG_RD,
    output logic [11:0] REG_ADDR,
    output logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA
);
    logic [31:0] d;
    initial {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
    // strobe for one cycle; read data lands the cycle after
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] x);
        @(posedge SYS_CLK) #1;
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, x};
        @(posedge SYS_CLK) #1;
        {REG_WR, REG_RD, REG_WDATA} = {2'b00, ~x};
        if (!w) d = REG_RDATA;
    endtask
endmodule
`default_nettype wire

// >>> dv/isb_irq_asserts.sv
// assertions on the mid-range interrupt status ports
`timescale 1ns/1ps
`default_nettype none
module isb_irq_asserts #(parameter int LEN_W = 16) (
    input wire logic SYS_CLK, RST, REG_WR, REG_RD, RX_FRAME_END, RX_KEPT_VALID, IRQ, POWER_IRQ_DIRECT,
    input wire logic [11:0] REG_ADDR, RX_KEPT_LEN,
    input wire logic [31:0] REG_WDATA, REG_RDATA,
    input wire logic [LEN_W-1:0] RX_FRAME_LEN
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    kept_pulse_a: assert property (RX_FRAME_END |=> RX_KEPT_VALID) else $error("no kept pulse");
    kept_clamp_a: assert property (RX_FRAME_END && RX_FRAME_LEN > 2048 |=> RX_KEPT_LEN == 12'h800)
        else $error("long frame not cut");
    kept_len_a: assert property (RX_FRAME_END && RX_FRAME_LEN <= 2048 |=> RX_KEPT_LEN == $past(RX_FRAME_LEN))
        else $error("kept length wrong");
    power_irq_a: assert property (POWER_IRQ_DIRECT |-> IRQ) else $error("power irq alone");
    rd_unmap_a: assert property (REG_RD && REG_ADDR != 12'h058 && REG_ADDR != 12'h05c |=> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    rd_rsvd_a: assert property (REG_RD |=> (REG_RDATA & 32'hffc40bff) == 32'h0) else $error("reserved bit read");
    irq_mask_a: assert property (REG_WR && REG_ADDR == 12'h05c && REG_WDATA == 32'h0 |=> !IRQ)
        else $error("irq with no enable");
    irq_reset_a: assert property (disable iff (1'b0) RST |=> !IRQ && !POWER_IRQ_DIRECT) else $error("irq in reset");
endmodule
`default_nettype wire

// >>> dv/test_irq_status_bits_mid_range.sv
// testbench for the mid-range interrupt status bits
`timescale 1ns/1ps
`default_nettype none
module test_irq_status_bits_mid_range;
    logic SYS_CLK = 0, RST = 1, TX_BUFFER_DONE = 0, COMPLETION_MARKER = 0, RX_TRANSFER_DONE = 0, POWER_EVENT = 0;
    logic TX_RESULT_QUEUE_OVERFLOW = 0, RX_FRAME_END = 0, RX_ERROR = 0, TX_ERROR = 0, PIN_PORT_PENDING = 0;
    logic TX_DATA_WRITE = 0, TX_DATA_FULL = 0, RX_KEPT_VALID, IRQ, POWER_IRQ_DIRECT, REG_WR, REG_RD;
    logic [15:0] GENERAL_TIMER_VALUE = 16'hffff, RX_FRAME_LEN = 0;
    logic [11:0] RX_KEPT_LEN, REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, sts = 0, en;
    int error_cnt = 0, comparisons = 0, len = 2047;
    int bits[11] = '{21, 20, 19, 17, 16, 15, 15, 15, 14, 13, 10};
    isb_irq_mid dut (.*);
    isb_host_model host (.*);
    initial forever #5 SYS_CLK = ~SYS_CLK;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic ev(input int b);
        @(posedge SYS_CLK) #1;
        case (b)
            21: {TX_BUFFER_DONE, COMPLETION_MARKER} = 2'b11;
            20: RX_TRANSFER_DONE = 1;
            19: GENERAL_TIMER_VALUE = 16'h0000;
            17: POWER_EVENT = 1;
            16: TX_RESULT_QUEUE_OVERFLOW = 1;
            15: {RX_FRAME_END, RX_FRAME_LEN} = {1'b1, 16'(len)};
            14: RX_ERROR = 1;
            13: TX_ERROR = 1;
            default: {TX_DATA_WRITE, TX_DATA_FULL} = 2'b11;
        endcase
        @(posedge SYS_CLK) #1;
        {TX_BUFFER_DONE, COMPLETION_MARKER, RX_TRANSFER_DONE, POWER_EVENT, TX_RESULT_QUEUE_OVERFLOW} = '0;
        {RX_FRAME_END, RX_ERROR, TX_ERROR, TX_DATA_WRITE, TX_DATA_FULL, GENERAL_TIMER_VALUE} = {5'h0, 16'hffff};
        sts[b] = b != 15 || len >= 2048;
        if (b == 15) begin
            chk(RX_KEPT_VALID, 1);
            chk(RX_KEPT_LEN, len > 2048 ? 2048 : len);
            len++;
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        host.acc(0, a, 0);
        chk(host.d, e);
    endtask
    initial begin
        void'($urandom(24));
        repeat (5) @(posedge SYS_CLK);
        #1 RST = 0;
        rdc(12'h058, 0);
        rdc(12'h100, 0);
        foreach (bits[i]) begin
            en = ($urandom | 32'h20000) & 32'h003bf400;
            host.acc(1, 12'h05c, en);
            ev(bits[i]);
            rdc(12'h058, sts);
            chk(IRQ, |(sts & en));
            chk(POWER_IRQ_DIRECT, sts[17]);
            host.acc(1, 12'h058, ~sts);
            rdc(12'h058, sts);
            host.acc(1, 12'h058, sts);
            sts = 0;
            rdc(12'h058, 0);
            $display("event test %0d done", bits[i]);
        end
        PIN_PORT_PENDING = 1;
        host.acc(1, 12'h05c, 32'hffffffff);
        host.acc(1, 12'h058, 32'hffffffff);
        rdc(12'h058, 32'h1000);
        rdc(12'h05c, 32'h003bf400);
        chk(IRQ, 1);
        PIN_PORT_PENDING = 0;
        host.acc(1, 12'h05c, 0);
        rdc(12'h058, 0);
        chk(IRQ, 0);
        $display("pin port test done");
        print_verdict;
    end
endmodule
bind isb_irq_mid isb_irq_asserts #(.LEN_W(LEN_W)) chk_i (.*);
`default_nettype wire

// >>> src/isb_frame_trunc.sv
// receive frame length clamp to the largest kept size
`timescale 1ns/1ps
`default_nettype none
`include "isb_params.svh"

module isb_frame_trunc #(
    parameter int LEN_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // frame end report
    input wire logic frame_end,
    input wire logic [LEN_W-1:0] frame_len,
    // clamped result
    output logic kept_valid,
    output logic [11:0] kept_len,
    output logic oversize
);
    isb_pkg::isb_trunc_t st;
    isb_pkg::isb_trunc_t next_st;
    logic valid_q;
    logic next_valid;

    always_comb begin
        next_st = st;
        next_valid = frame_end;
        if (frame_end) begin
            next_st.oversize = (frame_len >= LEN_W'(`ISB_FRAME_MAX)); // RULE8
            if (frame_len > LEN_W'(`ISB_FRAME_MAX)) begin
                next_st.kept_len = `ISB_FRAME_MAX; // RULE9
            end else begin
                next_st.kept_len = frame_len[11:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            valid_q <= 1'b0;
        end else begin
            st <= next_st;
            valid_q <= next_valid;
        end
    end

    assign kept_valid = valid_q;
    assign kept_len = st.kept_len;
    assign oversize = st.oversize;
endmodule

`default_nettype wire

// >>> src/isb_irq_mid.sv
// interrupt status bits 21..10 with enable gating and register port
`timescale 1ns/1ps
`default_nettype none
`include "isb_params.svh"

// Function
// RULE1: set bit 21 when a completion-marked buffer is fully in the tx queue
// RULE2: set bit 20 when the programmed rx transfer length has drained
// RULE3: set bit 19 when the general timer wraps from zero to ffff
// RULE4: set bit 17 on a power event, regardless of the power event pin
// RULE5: writing one clears bit 17; software first clears power control bits
// RULE6: power interrupt skips the de-assertion interval
// RULE7: set bit 16 when the tx result queue overflows
// RULE8: set bit 15 on a received frame of 2048 bytes or more
// RULE9: frames of 2049 bytes or more are cut to 2048 bytes
// RULE10: set bit 14 on a receiver error
// RULE11: set bit 13 on a transmitter error
// RULE12: bit 12 is read-only and mirrors the pin-port pending event
// RULE13: set bit 10 on a write to a full tx data queue
// RULE14: writing one clears a write-one-to-clear flag; zero leaves it
// RULE15: flags follow their sources whatever the enables say
// RULE16: interrupt output only for flags whose enable bit is set
// RULE17: reserved bits 18 and 11 read zero and ignore writes
module isb_irq_mid #(
    parameter int LEN_W = 16
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    // event sources
    input wire logic TX_BUFFER_DONE,
    input wire logic COMPLETION_MARKER,
    input wire logic RX_TRANSFER_DONE,
    input wire logic [15:0] GENERAL_TIMER_VALUE,
    input wire logic POWER_EVENT,
    input wire logic TX_RESULT_QUEUE_OVERFLOW,
    input wire logic RX_FRAME_END,
    input wire logic [LEN_W-1:0] RX_FRAME_LEN,
    input wire logic RX_ERROR,
    input wire logic TX_ERROR,
    input wire logic PIN_PORT_PENDING,
    input wire logic TX_DATA_WRITE,
    input wire logic TX_DATA_FULL,
    // outputs
    output logic RX_KEPT_VALID,
    output logic [11:0] RX_KEPT_LEN,
    output logic IRQ,
    output logic POWER_IRQ_DIRECT
);
    isb_pkg::isb_state_t st;
    isb_pkg::isb_state_t next_st;
    logic kept_valid;
    logic [11:0] kept_len;
    logic oversize;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] status_val;
    logic pwr_q;

    isb_frame_trunc #(.LEN_W(LEN_W)) u_trunc (
        .clk(SYS_CLK),
        .rst(RST),
        .frame_end(RX_FRAME_END),
        .frame_len(RX_FRAME_LEN),
        .kept_valid(kept_valid),
        .kept_len(kept_len),
        .oversize(oversize)
    );

    always_comb begin
        next_st = st;
        set_vec = '0;
        clr_vec = '0;
        set_vec[`ISB_BIT_TX_DONE] = TX_BUFFER_DONE & COMPLETION_MARKER; // RULE1
        set_vec[`ISB_BIT_RX_LEN] = RX_TRANSFER_DONE; // RULE2
        set_vec[`ISB_BIT_TIMER] = (st.timer_prev == 16'h0000) &&
            (GENERAL_TIMER_VALUE == `ISB_TIMER_WRAP); // RULE3
        set_vec[`ISB_BIT_POWER] = POWER_EVENT; // RULE4
        set_vec[`ISB_BIT_TXQ_OVF] = TX_RESULT_QUEUE_OVERFLOW; // RULE7
        set_vec[`ISB_BIT_RX_BIG] = kept_valid & oversize; // RULE8
        set_vec[`ISB_BIT_RX_ERR] = RX_ERROR; // RULE10
        set_vec[`ISB_BIT_TX_ERR] = TX_ERROR; // RULE11
        set_vec[`ISB_BIT_TXD_OVR] = TX_DATA_WRITE & TX_DATA_FULL; // RULE13
        if (REG_WR && REG_ADDR == `ISB_STS_OFFSET) begin
            clr_vec = REG_WDATA & `ISB_W1C_MASK; // RULE14 RULE5
        end
        // set wins over a same-cycle clear; flags ignore enables
        next_st.status = ((st.status & ~clr_vec) | set_vec) & `ISB_W1C_MASK; // RULE15
        next_st.status[`ISB_BIT_PINPORT] = PIN_PORT_PENDING; // RULE12
        if (REG_WR && REG_ADDR == `ISB_EN_OFFSET) begin
            next_st.enable = REG_WDATA & `ISB_MID_MASK; // RULE17
        end
        next_st.timer_prev = GENERAL_TIMER_VALUE;
        status_val = next_st.status & `ISB_MID_MASK; // RULE17
        next_st.irq = |(status_val & next_st.enable); // RULE16
        next_st.rdata = st.rdata;
        if (REG_RD) begin
            unique case (REG_ADDR)
                `ISB_STS_OFFSET: next_st.rdata = st.status & `ISB_MID_MASK; // RULE17
                `ISB_EN_OFFSET: next_st.rdata = st.enable;
                default: next_st.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            // timer history starts at the idle value so release cannot fake a wrap
            st <= '{status: `ISB_STS_RESET, enable: `ISB_EN_RESET, rdata: 32'h00000000, irq: 1'b0,
                timer_prev: `ISB_TIMER_WRAP};
            pwr_q <= 1'b0;
        end else begin
            st <= next_st;
            // power flag, gated by its enable bit, goes straight out, no de-assertion hold-off
            pwr_q <= next_st.status[`ISB_BIT_POWER] & next_st.enable[`ISB_BIT_POWER]; // RULE6
        end
    end

    assign REG_RDATA = st.rdata;
    assign IRQ = st.irq;
    assign POWER_IRQ_DIRECT = pwr_q;
    assign RX_KEPT_VALID = kept_valid;
    assign RX_KEPT_LEN = kept_len;
endmodule

`default_nettype wire

// >>> src/isb_params.svh
// constants for the mid-range interrupt status bits
`ifndef ISB_PARAMS_SVH
`define ISB_PARAMS_SVH

`define ISB_STS_OFFSET 12'h058
`define ISB_EN_OFFSET 12'h05c
`define ISB_BIT_TX_DONE 21
`define ISB_BIT_RX_LEN 20
`define ISB_BIT_TIMER 19
`define ISB_BIT_RSVD_HI 18
`define ISB_BIT_POWER 17
`define ISB_BIT_TXQ_OVF 16
`define ISB_BIT_RX_BIG 15
`define ISB_BIT_RX_ERR 14
`define ISB_BIT_TX_ERR 13
`define ISB_BIT_PINPORT 12
`define ISB_BIT_RSVD_LO 11
`define ISB_BIT_TXD_OVR 10
`define ISB_MID_MASK 32'h003bf400
`define ISB_W1C_MASK 32'h003be400
`define ISB_STS_RESET 32'h00000000
`define ISB_EN_RESET 32'h00000000
`define ISB_TIMER_WRAP 16'hffff
`define ISB_FRAME_MAX 12'h800

`endif

// >>> src/isb_pkg.sv
// types for the mid-range interrupt status bits
package isb_pkg;
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] enable;
        logic [31:0] rdata;
        logic irq;
        logic [15:0] timer_prev;
    } isb_state_t;

    typedef struct packed {
        logic [11:0] kept_len;
        logic oversize;
    } isb_trunc_t;
endpackage
